/* File: hw/rxd_deser.sv */
// rxd_deser: receive serial-to-parallel path with signal detect gating
// assumes serial clock, data and detect pins arrive asynchronous to clk;
// downstream framing logic runs on clk and may stall via par_word_ready
`timescale 1ns/1ps

// ----------------------------------------------------------------
// word fifo
// ----------------------------------------------------------------
module rxd_fifo
	import rxd_pkg::*;
#(
	parameter int W     = 16,
	parameter int DEPTH = 32,
	parameter int AW    = 5
)
(
	// clock and reset
	input  wire logic           clk,
	input  wire logic           nrst,
	// fill side
	input  wire logic           in_valid,
	output logic                in_ready,
	input  wire logic [W-1:0]   in_data,
	// drain side
	output logic                out_valid,
	input  wire logic           out_ready,
	output logic      [W-1:0]   out_data
);

	logic [W-1:0]   mem_reg [DEPTH];
	logic [AW:0]    wr_ptr_reg;
	logic [AW:0]    rd_ptr_reg;
	wire            empty;
	wire            full;
	wire            push;
	wire            pop;

	assign empty     = (wr_ptr_reg == rd_ptr_reg);
	assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
	                && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule

// ----------------------------------------------------------------
// top: deserialiser
// ----------------------------------------------------------------
module rxd_deser
	import rxd_pkg::*;
(
	// clock and reset
	input  wire logic           clk,
	input  wire logic           nrst,
	// serial line side
	input  wire logic           rx_serial_data_pos,
	input  wire logic           rx_serial_data_neg,
	input  wire logic           rx_serial_clock_pos,
	input  wire logic           rx_serial_clock_neg,
	// signal detect
	input  wire logic           sig_detect_diff_level,
	input  wire logic           sig_detect_logic_level,
	output logic                sd_diff_pull_out,
	output logic                sd_diff_pull_oe_n,
	// parallel side
	output logic      [15:0]    par_word_out,
	output logic                par_word_clock_pos,
	output logic                par_word_clock_neg,
	input  wire logic           par_word_ready,
	// status
	output logic                sig_detect_active,
	output logic                rx_overflow
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0]     dp_sync_reg;
	logic [1:0]     dn_sync_reg;
	logic [2:0]     ck_sync_reg;
	logic [1:0]     sdd_sync_reg;
	logic [1:0]     sdl_sync_reg;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			dp_sync_reg  <= SYNC_RST[1:0];
			dn_sync_reg  <= SYNC_RST[1:0];
			ck_sync_reg  <= SYNC_RST;
			sdd_sync_reg <= SYNC_RST[1:0];
			sdl_sync_reg <= SYNC_RST[1:0];
		end
		else
		begin
			dp_sync_reg  <= {dp_sync_reg[0], rx_serial_data_pos};
			dn_sync_reg  <= {dn_sync_reg[0], rx_serial_data_neg};
			ck_sync_reg  <= {ck_sync_reg[1:0],
			                 rx_serial_clock_pos & ~rx_serial_clock_neg};
			sdd_sync_reg <= {sdd_sync_reg[0], sig_detect_diff_level};
			sdl_sync_reg <= {sdl_sync_reg[0], sig_detect_logic_level};
		end
	end

	// ----------------------------------------------------------------
	// signal detect and data gating
	// ----------------------------------------------------------------
	wire            sd_diff;
	wire            sd_logic;
	wire            sd_eff;
	wire            line_bit;
	wire            gated_bit;
	wire            ser_rise;

	// weak pull-down: driven low, resolved as weak by the pad
	assign sd_diff_pull_out  = PULL_LEVEL;
	assign sd_diff_pull_oe_n = 1'b0;

	assign sd_diff   = sdd_sync_reg[1];
	assign sd_logic  = sdl_sync_reg[1];
	// diff detect high flips logic detect to active low; with logic
	// detect low, diff detect itself acts active high
	assign sd_eff    = sd_logic ^ sd_diff;
	// differential data: positive leg high and negative leg low is a one
	assign line_bit  = dp_sync_reg[1] & ~dn_sync_reg[1];
	assign gated_bit = sd_eff ? line_bit : FORCED_BIT;
	// rising edge of the supplied serial clock after synchronising
	assign ser_rise  = ck_sync_reg[1] & ~ck_sync_reg[2];

	// ----------------------------------------------------------------
	// shift register and bit counter
	// ----------------------------------------------------------------
	logic [15:0]    shift_reg;
	logic [15:0]    shift_next;
	logic [3:0]     bit_cnt_reg;
	logic [3:0]     bit_cnt_next;
	wire            word_done;

	assign shift_next   = {shift_reg[WORD_MSB-1:WORD_LSB], gated_bit};
	assign bit_cnt_next = bit_cnt_reg + 4'h1;
	assign word_done    = ser_rise && (bit_cnt_reg == BIT_CNT_LAST);

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			shift_reg   <= WORD_RST;
			bit_cnt_reg <= BIT_CNT_RST;
		end
		else if (ser_rise)
		begin
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// word hand-off state
	// ----------------------------------------------------------------
	rxd_state_t     state_reg;
	rxd_state_t     state_next;
	logic [15:0]    word_reg;
	wire            fifo_in_ready;
	wire            fifo_out_valid;
	wire [15:0]     fifo_out_data;
	wire            push_req;
	wire            drop;

	assign push_req = (state_reg == RXD_RUN);
	assign drop     = word_done && (state_reg == RXD_STALL);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			RXD_IDLE:
				if (word_done)
					state_next = RXD_RUN;
			RXD_RUN:
				if (word_done)
					state_next = RXD_RUN;
				else if (fifo_in_ready)
					state_next = RXD_IDLE;
				else
					state_next = RXD_STALL;
			RXD_STALL:
				if (fifo_in_ready)
					state_next = RXD_RUN;
			default:
				state_next = RXD_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_reg <= RXD_IDLE;
			word_reg  <= WORD_RST;
		end
		else
		begin
			state_reg <= state_next;
			if (word_done && (state_reg != RXD_STALL))
				word_reg <= shift_next;
		end
	end

	// ----------------------------------------------------------------
	// word buffer
	// ----------------------------------------------------------------
	wire            par_fall;
	wire            fifo_pop;

	assign fifo_pop = par_fall && par_word_ready;

	rxd_fifo
	#(
		.W      (WORD_W),
		.DEPTH  (FIFO_DEPTH),
		.AW     (FIFO_AW)
	)
	u_fifo
	(
		.clk        (clk),
		.nrst       (nrst),
		.in_valid   (push_req),
		.in_ready   (fifo_in_ready),
		.in_data    (word_reg),
		.out_valid  (fifo_out_valid),
		.out_ready  (fifo_pop),
		.out_data   (fifo_out_data)
	);

	// ----------------------------------------------------------------
	// parallel clock and output word
	// ----------------------------------------------------------------
	logic           par_clk_reg;
	logic           par_clk_n_reg;
	logic [15:0]    par_word_reg;
	logic           sd_reg;
	logic           ovf_reg;
	wire            par_clk_next;

	// high for bit counts 8..15, so it falls as each word completes
	assign par_clk_next = bit_cnt_next[PAR_CLK_BIT];
	assign par_fall     = ser_rise && par_clk_reg && !par_clk_next;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			par_clk_reg   <= PAR_CLK_RST;
			par_clk_n_reg <= !PAR_CLK_RST;
		end
		else if (ser_rise)
		begin
			par_clk_reg   <= par_clk_next;
			par_clk_n_reg <= !par_clk_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			par_word_reg <= WORD_RST;
		else if (fifo_pop && fifo_out_valid)
			par_word_reg <= fifo_out_data;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			sd_reg  <= 1'b0;
			ovf_reg <= 1'b0;
		end
		else
		begin
			sd_reg  <= sd_eff;
			ovf_reg <= drop;
		end
	end

	assign par_word_out       = par_word_reg;
	assign par_word_clock_pos = par_clk_reg;
	assign par_word_clock_neg = par_clk_n_reg;
	assign sig_detect_active  = sd_reg;
	assign rx_overflow        = ovf_reg;

endmodule

/* File: pkg/rxd_pkg.sv */
// rxd_pkg: constants for the receive deserialiser with signal detect
// assumes a single 40 MHz system clock that oversamples the serial clock
package rxd_pkg;

	// ----------------------------------------------------------------
	// clock
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_PS   = 25000;

	// ----------------------------------------------------------------
	// word layout
	// ----------------------------------------------------------------
	localparam int          WORD_W          = 16;
	localparam int          WORD_MSB        = 15;
	localparam int          WORD_LSB        = 0;
	localparam int          BIT_CNT_W       = 4;
	localparam logic [3:0]  BIT_CNT_LAST    = 4'hf;
	localparam logic [3:0]  BIT_CNT_HALF    = 4'h8;
	localparam int          PAR_CLK_BIT     = 3;

	// ----------------------------------------------------------------
	// buffering
	// ----------------------------------------------------------------
	localparam int          FIFO_DEPTH      = 32;
	localparam int          FIFO_AW         = 5;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] WORD_RST        = 16'h0000;
	localparam logic [3:0]  BIT_CNT_RST     = 4'h0;
	localparam logic        PAR_CLK_RST     = 1'b0;
	localparam logic [2:0]  SYNC_RST        = 3'h0;

	// ----------------------------------------------------------------
	// pin levels
	// ----------------------------------------------------------------
	localparam logic        FORCED_BIT      = 1'b0;
	localparam logic        PULL_LEVEL      = 1'b0;

	// ----------------------------------------------------------------
	// receive state
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		RXD_IDLE    = 2'b00,
		RXD_RUN     = 2'b01,
		RXD_STALL   = 2'b10
	} rxd_state_t;

endpackage

/* File: testbench/rxd_deser_props.sv */
// rxd_deser_props: port assertions for the deserialiser
// assumes a 40 MHz clk and a 200 ns serial clock sent in bursts
`timescale 1ns/1ps
module rxd_deser_props
	import rxd_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// line side
	input wire logic        rx_serial_clock_pos,
	input wire logic        rx_serial_clock_neg,
	input wire logic        sig_detect_diff_level,
	input wire logic        sig_detect_logic_level,
	// outputs
	input wire logic        sd_diff_pull_out,
	input wire logic        sd_diff_pull_oe_n,
	input wire logic [15:0] par_word_out,
	input wire logic        par_word_clock_pos,
	input wire logic        par_word_clock_neg,
	input wire logic        sig_detect_active,
	input wire logic        rx_overflow
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// --------
	// helpers
	// --------
	logic            pclk_q_reg;
	logic            sclk_q_reg;
	logic            seen_reg;
	logic [7:0]      half_cnt_reg;
	logic [3:0]      rise_age_reg;
	wire logic       eff_det = sig_detect_diff_level ^ sig_detect_logic_level;
	wire logic       sclk_hi = rx_serial_clock_pos & ~rx_serial_clock_neg;
	wire logic       pclk_edge = par_word_clock_pos ^ pclk_q_reg;
	wire logic [7:0] half_cnt_next = pclk_edge ? 8'h00 : half_cnt_reg + {7'h00, ~&half_cnt_reg};
	wire logic [3:0] rise_age_next = (sclk_hi & ~sclk_q_reg) ? 4'h0
		: rise_age_reg + {3'h0, ~&rise_age_reg};
	always_ff @(posedge clk)
	begin
		pclk_q_reg   <= par_word_clock_pos;
		sclk_q_reg   <= sclk_hi;
		seen_reg     <= nrst & (seen_reg | pclk_edge);
		half_cnt_reg <= nrst ? half_cnt_next : 8'h00;
		rise_age_reg <= nrst ? rise_age_next : 4'hf;
	end
	// --------
	// checks
	// --------
	pull_low_a: assert property (sd_diff_pull_oe_n == 1'b0 && sd_diff_pull_out == PULL_LEVEL)
		else $error("detect pull not active");
	clk_pair_a: assert property (par_word_clock_neg == ~par_word_clock_pos)
		else $error("parallel clock legs not complementary");
	det_on_a: assert property (eff_det [*5] |-> sig_detect_active)
		else $error("detect not active");
	det_off_a: assert property (!eff_det [*5] |-> !sig_detect_active)
		else $error("detect not inactive");
	word_fall_a: assert property ($changed(par_word_out) |-> $fell(par_word_clock_pos))
		else $error("word changed off the clock fall");
	word_hold_a: assert property ($fell(par_word_clock_pos) |=> $stable(par_word_out) [*8])
		else $error("word not held after fall");
	half_period_a: assert property (pclk_edge && seen_reg |-> half_cnt_reg >= 8'h3d)
		else $error("parallel clock half period short");
	serial_cause_a: assert property ($changed(par_word_clock_pos) |-> rise_age_reg <= 4'h5)
		else $error("parallel clock moved without serial rise");
	cover property ($fell(par_word_clock_pos) && sig_detect_active);
	cover property ($fell(par_word_clock_pos) && !sig_detect_active);
	cover property (rx_overflow);
endmodule

bind rxd_deser rxd_deser_props u_props (.clk(clk), .nrst(nrst),
	.rx_serial_clock_pos(rx_serial_clock_pos), .rx_serial_clock_neg(rx_serial_clock_neg),
	.sig_detect_diff_level(sig_detect_diff_level), .sig_detect_logic_level(sig_detect_logic_level),
	.sd_diff_pull_out(sd_diff_pull_out), .sd_diff_pull_oe_n(sd_diff_pull_oe_n),
	.par_word_out(par_word_out), .par_word_clock_pos(par_word_clock_pos),
	.par_word_clock_neg(par_word_clock_neg), .sig_detect_active(sig_detect_active),
	.rx_overflow(rx_overflow));

/* File: testbench/rxd_optic_model.sv */
// rxd_optic_model: optical receiver with clock recovery on the line side
// assumes the bench calls set_detect and send_word; serial clock idles low
`timescale 1ns/1ps
module rxd_optic_model
(
	// serial line
	output logic data_pos,
	output logic data_neg,
	output logic sclk_pos,
	output logic sclk_neg,
	// detect
	output logic det_logic
);
	assign data_neg = ~data_pos;
	assign sclk_neg = ~sclk_pos;
	initial
	begin
		data_pos = 1'b0;
		sclk_pos = 1'b0;
		det_logic = 1'b1;
	end
	task automatic set_detect(input logic v);
		det_logic = v;
	endtask
	// first bit first, data moves on the serial fall
	task automatic send_word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--)
		begin
			data_pos = w[i];
			#100;
			sclk_pos = 1'b1;
			#100;
			sclk_pos = 1'b0;
		end
		data_pos = ~w[0];
	endtask
endmodule

/* File: testbench/rxd_deser_tb.sv */
// rxd_deser_tb: self-checking bench for the receive deserialiser
// assumes the optic model drives the line and the bench straps detect polarity
`timescale 1ns/1ps
module rxd_deser_tb;
	import rxd_pkg::*;
	logic        clk = 1'b0;
	logic        nrst;
	logic        par_word_ready;
	logic        strap_hi;
	logic        pclk_q;
	int          hi_run;
	int          ovf_seen = 0;
	int          miscompares = 0;
	int          cmp_count = 0;
	logic [15:0] cap[$];
	wire logic   d_pos, d_neg, s_pos, s_neg, det_logic, sd_diff, pull_out, pull_oe_n;
	wire logic   pclk_pos, pclk_neg, det_active, ovf;
	wire logic [15:0] word;

	always #12.5 clk = ~clk;
	assign (weak0, weak1) sd_diff = pull_oe_n ? 1'bz : pull_out;
	assign sd_diff = strap_hi ? 1'b1 : 1'bz;

	rxd_optic_model om (.data_pos(d_pos), .data_neg(d_neg), .sclk_pos(s_pos), .sclk_neg(s_neg),
		.det_logic(det_logic));
	rxd_deser DUT (.clk(clk), .nrst(nrst), .rx_serial_data_pos(d_pos), .rx_serial_data_neg(d_neg),
		.rx_serial_clock_pos(s_pos), .rx_serial_clock_neg(s_neg), .sig_detect_diff_level(sd_diff),
		.sig_detect_logic_level(det_logic), .sd_diff_pull_out(pull_out),
		.sd_diff_pull_oe_n(pull_oe_n), .par_word_out(word), .par_word_clock_pos(pclk_pos),
		.par_word_clock_neg(pclk_neg), .par_word_ready(par_word_ready),
		.sig_detect_active(det_active), .rx_overflow(ovf));

	// capture the word at each parallel clock fall, sampled mid-cycle once settled
	always @(negedge clk)
	begin
		pclk_q <= pclk_pos;
		if (pclk_pos)
			hi_run <= pclk_q ? hi_run + 1 : 1;
		if (pclk_q && !pclk_pos)
			cap.push_back(word);
		if (ovf)
			ovf_seen++;
	end

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] expv);
		cmp_count++;
		if (seen !== expv)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, expv, seen);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// words back to back plus one flush word; output lags one word
	task automatic stream(input logic [15:0] w[$], input logic [15:0] expv[$]);
		int n;
		n = 0;
		cap.delete();
		#3;
		foreach (w[i])
			om.send_word(w[i]);
		om.send_word(16'h0f0f);
		while (cap.size() <= w.size() && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		if (cap.size() <= w.size())
		begin
			miscompares++;
			give_verdict();
		end
		foreach (expv[i])
			chk("word", cap[i + 1], expv[i]);
	endtask

	task automatic s_order();
		logic [15:0] q[$] = '{16'h8000, 16'h0001, 16'hffff, 16'h1234, 16'ha5c3};
		stream(q, q);
		chk("half", 16'(hi_run >= 62 && hi_run <= 66), 16'h0001);
	endtask

	task automatic s_detect();
		logic act;
		for (int c = 0; c < 4; c++)
		begin
			@(negedge clk);
			strap_hi = c[1];
			om.set_detect(c[0]);
			act = c[1] ^ c[0];
			repeat (6) @(negedge clk);
			chk("active", 16'(det_active), 16'(act));
			stream('{16'hc3a5}, '{act ? 16'hc3a5 : 16'h0000});
		end
	endtask

	task automatic s_fill();
		logic [15:0] fw[$];
		logic [15:0] zw[$];
		@(negedge clk);
		par_word_ready = 1'b0;
		strap_hi = 1'b0;
		om.set_detect(1'b1);
		repeat (6) @(negedge clk);
		for (int i = 0; i < 32; i++)
			om.send_word(16'h1000 + 16'(i));
		@(negedge clk);
		par_word_ready = 1'b1;
		for (int i = 0; i < 31; i++)
		begin
			fw.push_back(16'h1000 + 16'(i));
			zw.push_back(16'h0000);
		end
		stream(zw, fw);
		chk("overflow", 16'(ovf_seen), 16'h0001);
	endtask

	initial
	begin
		nrst = 1'b0;
		par_word_ready = 1'b1;
		strap_hi = 1'b0;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		s_order();
		s_detect();
		s_fill();
		give_verdict();
	end
endmodule
